// ===== bench/wit_timer_tb.sv
// Self-checking bench for the watchdog/interval timer.
// Assumes one-cycle bus strobes answered by busAck one cycle later.
`timescale 1ns/1ps
`include "wit_map.svh"
module wit_timer_tb
   import wit_pkg::*;
;
   logic            clk = 1'b0;
   logic            resetN;
   wit_bus_req_type busReq;
   logic            standbyEnter;
   logic [15:0]     busRdata;
   logic            busAck;
   logic            intervalIrq;
   logic            chipReset;
   logic [15:0]     rdata;
   int              numErrors = 0;
   int              checked = 0;
   int              cycles = 0;
   int              divs [8] = '{2, 32, 64, 128, 256, 512, 2048, 4096};

   wit_timer wit_timer_inst (
      .clk          (clk),
      .reset_n      (resetN),
      .busReq       (busReq),
      .standbyEnter (standbyEnter),
      .busRdata     (busRdata),
      .busAck       (busAck),
      .intervalIrq  (intervalIrq),
      .chipReset    (chipReset)
   );

   always #5 clk = ~clk;

   task automatic results();
      $display("errors %0d checks %0d", numErrors, checked);
      if (numErrors == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles >= 60000) begin
         numErrors++;
         results();
      end
   end

   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp) begin
         numErrors++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic acc(input logic rd, input logic wr, input logic word, input logic [19:0] addr,
                      input logic [15:0] wdata);
      @(posedge clk);
      #1;
      busReq = '{rd, wr, word, addr, wdata};
      @(posedge clk);
      #1;
      busReq = '0;
      rdata = busRdata;
      chk("busAck", 16'h0001, {15'h0000, busAck});
   endtask

   task automatic wr16(input logic [19:0] addr, input logic [15:0] wdata);
      acc(1'b0, 1'b1, 1'b1, addr, wdata);
   endtask

   task automatic rd8(input logic [19:0] addr, input string name, input logic [15:0] exp);
      acc(1'b1, 1'b0, 1'b0, addr, 16'h0000);
      chk(name, exp, rdata);
   endtask

   task automatic doReset();
      resetN = 1'b0;
      repeat (20) @(posedge clk);
      #1;
      resetN = 1'b1;
   endtask

   task automatic testResetValues();
      rd8(`WIT_ADDR_CTRL, "control", 16'h0018);
      rd8(`WIT_ADDR_CNT, "counter", 16'h0000);
      rd8(`WIT_ADDR_RST_RD, "status", 16'h003f);
      rd8(20'hfff90, "unmapped", 16'h0000);
   endtask

   task automatic testProtection();
      acc(1'b0, 1'b1, 1'b0, `WIT_ADDR_CTRL, 16'ha527);
      rd8(`WIT_ADDR_CTRL, "byte write", 16'h0018);
      wr16(`WIT_ADDR_CTRL, 16'h3c27);
      rd8(`WIT_ADDR_CTRL, "bad password", 16'h0018);
      wr16(`WIT_ADDR_CTRL, 16'ha507);
      rd8(`WIT_ADDR_CTRL, "reserved bits", 16'h001f);
      wr16(`WIT_ADDR_CTRL, 16'ha500);
      wr16(`WIT_ADDR_CTRL, 16'h5a33);
      rd8(`WIT_ADDR_CNT, "stopped counter", 16'h0000);
   endtask

   task automatic testInterval();
      wr16(`WIT_ADDR_CTRL, 16'ha520);
      wr16(`WIT_ADDR_CTRL, 16'h5af0);
      for (int i = 0; i < 100 && intervalIrq !== 1'b1; i++) begin
         @(posedge clk);
         #1;
      end
      chk("irq raised", 16'h0001, {15'h0000, intervalIrq});
      wr16(`WIT_ADDR_CTRL, 16'ha520);
      rd8(`WIT_ADDR_CTRL, "flag kept unread", 16'h00b8);
      rd8(`WIT_ADDR_CTRL, "flag set", 16'h00b8);
      wr16(`WIT_ADDR_CTRL, 16'ha5a0);
      rd8(`WIT_ADDR_CTRL, "flag write one", 16'h00b8);
      wr16(`WIT_ADDR_CTRL, 16'ha520);
      rd8(`WIT_ADDR_CTRL, "flag cleared", 16'h0038);
      chk("irq dropped", 16'h0000, {15'h0000, intervalIrq});
      wr16(`WIT_ADDR_CTRL, 16'h5a40);
      acc(1'b1, 1'b0, 1'b0, `WIT_ADDR_CNT, 16'h0000);
      chk("counter load", 16'h0040, rdata & 16'hfffe);
      wr16(`WIT_ADDR_CTRL, 16'ha500);
      rd8(`WIT_ADDR_CNT, "run cleared", 16'h0000);
   endtask

   task automatic testSelect();
      for (int c = 0; c < 8; c++) begin
         wr16(`WIT_ADDR_CTRL, {`WIT_PW_CTRL, 5'h04, c[2:0]});
         repeat (4 * divs[c]) @(posedge clk);
         acc(1'b1, 1'b0, 1'b0, `WIT_ADDR_CNT, 16'h0000);
         chk("tick count", 16'h0001, {15'h0000, rdata[7:0] >= 8'h03 && rdata[7:0] <= 8'h06});
         wr16(`WIT_ADDR_CTRL, {`WIT_PW_CTRL, 5'h00, c[2:0]});
      end
   endtask

   task automatic testWatchdog();
      int n;
      n = 0;
      wr16(`WIT_ADDR_CTRL, 16'ha560);
      wr16(`WIT_ADDR_CTRL, 16'h5afc);
      for (int i = 0; i < 100 && chipReset !== 1'b1; i++) begin
         @(posedge clk);
         #1;
      end
      while (chipReset === 1'b1 && n < 1000) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk("reset length", 16'd518, n[15:0]);
      rd8(`WIT_ADDR_RST_RD, "flag after wdt", 16'h00bf);
      rd8(`WIT_ADDR_CTRL, "control after wdt", 16'h0018);
      wr16(`WIT_ADDR_RST_WR, 16'ha540);
      rd8(`WIT_ADDR_RST_RD, "status write", 16'h007f);
      doReset();
      rd8(`WIT_ADDR_RST_RD, "status pin reset", 16'h003f);
   endtask

   task automatic testStandby();
      wr16(`WIT_ADDR_CTRL, 16'ha547);
      @(posedge clk);
      #1;
      standbyEnter = 1'b1;
      @(posedge clk);
      #1;
      standbyEnter = 1'b0;
      rd8(`WIT_ADDR_CTRL, "standby", 16'h001f);
   endtask

   initial begin
      busReq = '0;
      standbyEnter = 1'b0;
      doReset();
      testResetValues();
      testProtection();
      testInterval();
      testSelect();
      testWatchdog();
      testStandby();
      results();
   end
endmodule

// ===== inc/wit_map.svh
// Address map, field positions, reset values and timing counts of the watchdog/interval timer.
// Assumes 20-bit internal byte addresses and a 100 MHz system clock.
`ifndef WIT_MAP_SVH
`define WIT_MAP_SVH

// Shared write address of control and counter, and read addresses
`define WIT_ADDR_CTRL      20'hfff8c
`define WIT_ADDR_CNT       20'hfff8d
`define WIT_ADDR_RST_WR    20'hfff8e
`define WIT_ADDR_RST_RD    20'hfff8f

// Write passwords in the upper byte of a word write
`define WIT_PW_CNT         8'h5a
`define WIT_PW_CTRL        8'ha5
`define WIT_PW_RST         8'ha5

// Field positions
`define WIT_CS_OVF         7
`define WIT_CS_MODE        6
`define WIT_CS_RUN         5
`define WIT_RS_FLAG        7
`define WIT_RS_SPARE       6

// Reset values and bits that always read 1
`define WIT_CS_RESET       8'h18
`define WIT_CNT_RESET      8'h00
`define WIT_RS_RESET       8'h3f
`define WIT_CS_ONES        8'h18
`define WIT_RS_ONES        8'h3f
`define WIT_CNT_MAX        8'hff

// Prescaler tap masks for divide by 2 .. 4096
`define WIT_TAP0           12'h001
`define WIT_TAP1           12'h01f
`define WIT_TAP2           12'h03f
`define WIT_TAP3           12'h07f
`define WIT_TAP4           12'h0ff
`define WIT_TAP5           12'h1ff
`define WIT_TAP6           12'h7ff
`define WIT_TAP7           12'hfff

// Internal reset length in system clock states
`define WIT_RESET_STATES   518
`define WIT_RESET_CYCLES   (`WIT_RESET_STATES)

`endif

// ===== inc/wit_pkg.sv
// Types shared by the watchdog/interval timer.
// Assumes the address map header is included where offsets are needed.
package wit_pkg;

   // One internal bus access, valid for one cycle
   typedef struct packed {
      logic        rd;
      logic        wr;
      logic        word;
      logic [19:0] addr;
      logic [15:0] wdata;
   } wit_bus_req_type;

endpackage

// ===== src/wit_timer.sv
// Watchdog and interval timer with password-protected registers.
// Assumes one-cycle bus strobes from logic on clk and reset_n taken from the reset pin.
`timescale 1ns/1ps
`include "wit_map.svh"

// Functional notes
// - Eight-bit up-counter advances on each selected prescaler pulse while running.
// - Counter wrap from maximum to zero sets the overflow flag.
// - Run bit low forces counter to zero; reset clears it too.
// - Clock select codes 0..7 pick divide by 2,32,64,128,256,512,2048,4096.
// - Overflow flag clears by writing 0 after reading it as 1, and on reset or standby.
// - Mode 0: overflow requests interrupt; mode 1: overflow resets chip.
// - Watchdog overflow that resets the chip sets the watchdog reset flag.
// - Reset pin, or writing 0 after reading 1, clears the watchdog flag.
// - Reset status bits 7 and 6 survive the watchdog's own reset.
// - Control bits 7..5 clear on reset and standby; 2..0 only on reset.
// - Control bits 4 and 3 ignore writes and read as one.
// - Reset status bit 6 is storage; bits 5..0 read as one.
// - Shared word write address; upper byte password picks counter or control.
// - Byte writes never change counter or control register.
// - Reset status written by word with password; 0 in bit 7 clears flag.
// - Byte reads at base, base+1 and base+3 return the three registers.
// - Watchdog internal reset lasts 518 system clock states.
// - Reset pin takes priority over a simultaneous watchdog reset.
// - Counter write in the same cycle as a count pulse wins.
module wit_timer
   import wit_pkg::*;
(
   input  wire logic            clk,
   input  wire logic            reset_n,
   input  wire wit_bus_req_type busReq,
   input  wire logic            standbyEnter,
   output logic [15:0]          busRdata,
   output logic                 busAck,
   output logic                 intervalIrq,
   output logic                 chipReset
);

   logic [11:0] prescale_reg;
   logic [7:0]  cnt_reg;
   logic        ovf_reg;
   logic        mode_reg;
   logic        run_reg;
   logic [2:0]  sel_reg;
   logic        ovfSeen_reg;
   logic        flag_reg;
   logic        flagSeen_reg;
   logic        spare_reg;
   logic [15:0] rdata_reg;
   logic        ack_reg;
   logic        irq_reg;
   logic        intReset_reg;
   logic [9:0]  resetCnt_reg;

   logic [11:0] tapMask;
   logic        tick;
   logic        wordWrite;
   logic        cntWrite;
   logic        ctrlWrite;
   logic        rstWrite;
   logic        ovfEvent;
   logic [7:0]  ctrlByte;
   logic [7:0]  rstByte;
   logic        readsCtrl;
   logic        readsRst;

   localparam logic [9:0] RESET_LAST = 10'(`WIT_RESET_CYCLES - 1);
   localparam logic [7:0] CS_RESET   = `WIT_CS_RESET;
   localparam logic [7:0] RS_RESET   = `WIT_RS_RESET;

   always_comb begin
      unique case (sel_reg)
         3'h0: tapMask = `WIT_TAP0;
         3'h1: tapMask = `WIT_TAP1;
         3'h2: tapMask = `WIT_TAP2;
         3'h3: tapMask = `WIT_TAP3;
         3'h4: tapMask = `WIT_TAP4;
         3'h5: tapMask = `WIT_TAP5;
         3'h6: tapMask = `WIT_TAP6;
         3'h7: tapMask = `WIT_TAP7;
      endcase
   end

   assign tick = &(prescale_reg | ~tapMask);

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         prescale_reg <= 12'h000;
      end else begin
         prescale_reg <= prescale_reg + 12'h001;
      end
   end

   assign wordWrite = busReq.wr && busReq.word && !intReset_reg;
   assign cntWrite  = wordWrite && busReq.addr == `WIT_ADDR_CTRL && busReq.wdata[15:8] == `WIT_PW_CNT;
   assign ctrlWrite = wordWrite && busReq.addr == `WIT_ADDR_CTRL && busReq.wdata[15:8] == `WIT_PW_CTRL;
   assign rstWrite  = wordWrite && busReq.addr == `WIT_ADDR_RST_WR && busReq.wdata[15:8] == `WIT_PW_RST;

   assign ovfEvent = run_reg && tick && !cntWrite && cnt_reg == `WIT_CNT_MAX;

   assign ctrlByte = {ovf_reg, mode_reg, run_reg, 2'b00, sel_reg} | `WIT_CS_ONES;
   assign rstByte  = {flag_reg, spare_reg, 6'h00} | `WIT_RS_ONES;

   assign readsCtrl = busReq.rd && busReq.addr == `WIT_ADDR_CTRL;
   assign readsRst  = busReq.rd && (busReq.addr == `WIT_ADDR_RST_RD
                      || (busReq.word && busReq.addr == `WIT_ADDR_RST_WR));

   always_ff @(posedge clk) begin
      if (!reset_n || intReset_reg) begin
         cnt_reg <= `WIT_CNT_RESET;
      end else if (!run_reg) begin
         cnt_reg <= `WIT_CNT_RESET;
      end else if (cntWrite) begin
         cnt_reg <= busReq.wdata[7:0];
      end else if (tick) begin
         cnt_reg <= cnt_reg + 8'h01;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n || intReset_reg) begin
         mode_reg <= CS_RESET[`WIT_CS_MODE];
         run_reg  <= CS_RESET[`WIT_CS_RUN];
         sel_reg  <= CS_RESET[2:0];
      end else if (standbyEnter) begin
         mode_reg <= 1'b0;
         run_reg  <= 1'b0;
      end else if (ctrlWrite) begin
         mode_reg <= busReq.wdata[`WIT_CS_MODE];
         run_reg  <= busReq.wdata[`WIT_CS_RUN];
         sel_reg  <= busReq.wdata[2:0];
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n || intReset_reg || standbyEnter) begin
         ovf_reg     <= 1'b0;
         ovfSeen_reg <= 1'b0;
      end else if (ovfEvent) begin
         ovf_reg <= 1'b1;
      end else if (ctrlWrite && !busReq.wdata[`WIT_CS_OVF] && ovfSeen_reg) begin
         ovf_reg     <= 1'b0;
         ovfSeen_reg <= 1'b0;
      end else if (readsCtrl && ovf_reg) begin
         ovfSeen_reg <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         flag_reg     <= RS_RESET[`WIT_RS_FLAG];
         spare_reg    <= RS_RESET[`WIT_RS_SPARE];
         flagSeen_reg <= 1'b0;
      end else if (ovfEvent && mode_reg) begin
         flag_reg <= 1'b1;
      end else if (rstWrite) begin
         spare_reg <= busReq.wdata[`WIT_RS_SPARE];
         if (!busReq.wdata[`WIT_RS_FLAG] && flagSeen_reg) begin
            flag_reg     <= 1'b0;
            flagSeen_reg <= 1'b0;
         end
      end else if (readsRst && flag_reg) begin
         flagSeen_reg <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         intReset_reg <= 1'b0;
         resetCnt_reg <= 10'h000;
      end else if (intReset_reg) begin
         resetCnt_reg <= resetCnt_reg + 10'h001;
         if (resetCnt_reg == RESET_LAST) begin
            intReset_reg <= 1'b0;
         end
      end else if (ovfEvent && mode_reg) begin
         intReset_reg <= 1'b1;
         resetCnt_reg <= 10'h000;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n || intReset_reg) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= (ovf_reg || ovfEvent) && !mode_reg && !standbyEnter
                    && !(ctrlWrite && !busReq.wdata[`WIT_CS_OVF] && ovfSeen_reg && !ovfEvent);
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         rdata_reg <= 16'h0000;
         ack_reg   <= 1'b0;
      end else begin
         ack_reg <= busReq.rd || busReq.wr;
         if (!busReq.rd) begin
            rdata_reg <= 16'h0000;
         end else if (busReq.word) begin
            unique case (busReq.addr)
               `WIT_ADDR_CTRL:   rdata_reg <= {ctrlByte, cnt_reg};
               `WIT_ADDR_RST_WR: rdata_reg <= {8'h00, rstByte};
               default:          rdata_reg <= 16'h0000;
            endcase
         end else begin
            unique case (busReq.addr)
               `WIT_ADDR_CTRL:   rdata_reg <= {8'h00, ctrlByte};
               `WIT_ADDR_CNT:    rdata_reg <= {8'h00, cnt_reg};
               `WIT_ADDR_RST_RD: rdata_reg <= {8'h00, rstByte};
               default:          rdata_reg <= 16'h0000;
            endcase
         end
      end
   end

   assign busRdata    = rdata_reg;
   assign busAck      = ack_reg;
   assign intervalIrq = irq_reg;
   assign chipReset   = intReset_reg;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   sequence s_ovfRead;
      readsCtrl && ovf_reg && !ovfEvent;
   endsequence

   sequence s_zeroWrite;
      ctrlWrite && !busReq.wdata[`WIT_CS_OVF] && !ovfEvent && !standbyEnter;
   endsequence

   a_halt_zero: assert property (
      !run_reg && !cntWrite |=> cnt_reg == `WIT_CNT_RESET)
      else $error("counter not zero while halted");

   a_count_step: assert property (
      run_reg && tick && !cntWrite && !intReset_reg && !standbyEnter |=> cnt_reg == $past(cnt_reg) + 8'h01)
      else $error("counter did not advance on tick");

   a_write_wins: assert property (
      cntWrite && run_reg && !standbyEnter |=> cnt_reg == $past(busReq.wdata[7:0]))
      else $error("counter write lost");

   a_ovf_set: assert property (
      ovfEvent && !mode_reg && !standbyEnter |=> ovf_reg ##1 intervalIrq)
      else $error("overflow flag or request missing");

   a_ovf_clear: assert property (
      s_ovfRead ##1 (!ovfEvent && !intReset_reg && !standbyEnter) [*2] ##0 s_zeroWrite |=> !ovf_reg)
      else $error("overflow flag not cleared after read");

   a_ovf_noread: assert property (
      ovf_reg && !ovfSeen_reg && !readsCtrl && ctrlWrite && !standbyEnter |=> ovf_reg)
      else $error("overflow flag cleared without read");

   a_wd_reset: assert property (
      ovfEvent && mode_reg |=> chipReset && flag_reg)
      else $error("watchdog overflow without reset and flag");

   a_reset_len: assert property (
      $fell(intReset_reg) |-> $past(resetCnt_reg) == RESET_LAST)
      else $error("internal reset length wrong");

   a_flag_keep: assert property (
      intReset_reg && flag_reg |=> flag_reg)
      else $error("watchdog flag lost in own reset");

   a_bad_pw: assert property (
      wordWrite && busReq.addr == `WIT_ADDR_CTRL && !cntWrite && !ctrlWrite
         && !standbyEnter && !tick |=> $stable(cnt_reg) && $stable(sel_reg))
      else $error("write without password changed state");

   a_byte_write: assert property (
      busReq.wr && !busReq.word && !tick && !standbyEnter && !intReset_reg |=> $stable(cnt_reg) && $stable(sel_reg) && $stable(mode_reg))
      else $error("byte write took effect");

   a_ones_read: assert property (
      busReq.rd && !busReq.word && busReq.addr == `WIT_ADDR_CTRL |=> busRdata[4:3] == 2'b11)
      else $error("reserved control bits not one");

endmodule
